// file: fcs_consts.vh
`ifndef FCS_CONSTS_VH
`define FCS_CONSTS_VH

// command cycle addresses and codes
`define FCS_UNLOCK1_ADDR  20'hF5556
`define FCS_UNLOCK2_ADDR  20'hEAAAA
`define FCS_CHIP_ADDR     20'hE5556
`define FCS_UNLOCK1_DATA  16'hAAAA
`define FCS_UNLOCK2_DATA  16'h5555
`define FCS_CMD_PROG      16'hA0A0
`define FCS_CMD_ESETUP    16'h8080
`define FCS_CMD_CHIP      16'h1010
`define FCS_CMD_SECTOR    16'h3030
`define FCS_CMD_RESUME    16'h3030
`define FCS_CMD_SUSPEND   16'hB0B0

// timing and sector limit
`define FCS_CLK_MHZ       100
`define FCS_TOUT_US       50
`define FCS_SUSP_US       20
`define FCS_MAX_SECTORS   6

// apb register map
`define FCS_STAT_OFS      12'h000
`define FCS_STAT_RDY_BIT  0
`define FCS_STAT_FLAG_BIT 1
`define FCS_STAT_IEN_BIT  2
`define FCS_STAT_WIN_BIT  3
`define FCS_STAT_SUSP_BIT 4

// polled status bit positions
`define FCS_POLL_BIT      7
`define FCS_TOG6_BIT      6
`define FCS_WIN_BIT       3
`define FCS_TOG2_BIT      2

// reset values
`define FCS_RST_IEN       1'b0
`define FCS_RST_FLAG      1'b0

`endif

// file: fcs_flash_command_sequencer.v
// Summary of operation
// - program takes two unlocks, setup code, then address and data; write starts on last
// - after acceptance the sequencer times its own pulse and verifies unaided
// - programming ends with polled bit 7 equal to data bit 7; back to read
// - every command write is ignored while programming
// - program targets may come in any order and across sectors
// - programming only clears bits; only erase sets them back to one
// - chip erase takes six writes: unlocks, setup, unlocks, chip code
// - erase first programs every affected cell to zero, then erases
// - chip erase starts on final write, ends with bit 7 at one, then read
// - sector erase takes six writes ending with sector code at sector address
// - each sector code opens a 50 us window; erase starts when it expires
// - polled bit 3 shows whether the window has closed
// - any other command but suspend in the window returns to read, dropping the sectors
// - pending buffer holds any combination of zero to six sectors
// - sector erase ends with bit 7 at one; commands but suspend ignored; polling anywhere
// - suspend honoured only in sector erase or its window, at any address
// - suspend inside the window ends it and enters suspended state
// - suspend during erasure halts it within 20 us
// - suspended: ready and bit 7 at one, bit 6 stops toggling
// - suspended: other sectors read data, suspended sector toggles bit 2
// - program while suspended only programs sectors not being erased
// - resume code restarts erase; suspend accepted again afterwards
// - bad address, data or order aborts the sequence to read mode
// - half-word commands with fixed unlock addresses and codes
// - while busy ready reads 0, commands refused except in the window and suspend in sector erase, reads give status
// - completion flag set on busy to ready; irq while flag and enable
`timescale 1ns/1ns
`default_nettype none
`include "fcs_consts.vh"

module fcs_flash_command_sequencer #(
  parameter MEM_AW   = 10,
  parameter SB       = 3,
  parameter STEP_CYC = 4,
  parameter PROG_CYC = 8,
  parameter TOUT_CYC = `FCS_TOUT_US * `FCS_CLK_MHZ
) (
  input  wire        clk,             // system clock
  input  wire        rst,             // synchronous reset, high
  input  wire        fl_wr,           // half-word write strobe
  input  wire        fl_rd,           // half-word read strobe
  input  wire [19:0] fl_addr,         // flash byte offset
  input  wire [15:0] fl_wdata,        // write half-word
  output reg  [15:0] fl_rdata_ff,     // read half-word
  output reg         fl_rvalid_ff,    // read data valid pulse
  input  wire        psel,            // apb select
  input  wire        penable,         // apb enable
  input  wire        pwrite,          // apb direction
  input  wire [11:0] paddr,           // apb address
  input  wire [31:0] pwdata,          // apb write data
  output reg  [31:0] prdata_ff,       // apb read data
  output reg         pready_ff,       // apb ready
  output reg         pslverr_ff,      // apb error
  output reg         ready_busy_line_ff, // high when idle
  output reg         op_done_irq_ff   // completion interrupt
);

  localparam DEPTH    = 1 << MEM_AW;
  localparam NSECT    = 1 << SB;
  localparam SUSP_CYC = `FCS_SUSP_US * `FCS_CLK_MHZ;

  localparam OP_READ  = 3'd0;
  localparam OP_PROG  = 3'd1;
  localparam OP_WIN   = 3'd2;
  localparam OP_ERASE = 3'd3;
  localparam OP_SUSP  = 3'd4;
  localparam OP_SPROG = 3'd5;

  localparam C_IDLE = 3'd0;
  localparam C_U1   = 3'd1;
  localparam C_U2   = 3'd2;
  localparam C_PSET = 3'd3;
  localparam C_ESET = 3'd4;
  localparam C_EU1  = 3'd5;
  localparam C_EU2  = 3'd6;

  reg [15:0]       mem [0:DEPTH-1];
  reg [2:0]        op_ff;
  reg [2:0]        cmd_ff;
  reg [12:0]       win_cnt_ff;
  reg [15:0]       step_cnt_ff;
  reg [MEM_AW-1:0] ptr_ff;
  reg              phase_ff;
  reg              chip_ff;
  reg [NSECT-1:0]  mask_ff;
  reg [2:0]        nsec_ff;
  reg [MEM_AW-1:0] pa_ff;
  reg [15:0]       pd_ff;
  reg              susp_req_ff;
  reg              tog6_ff;
  reg              tog2_ff;
  reg              flag_ff;
  reg              ien_ff;

  reg [2:0]        nxt_op;
  reg [2:0]        nxt_cmd;
  reg [12:0]       nxt_win_cnt;
  reg [15:0]       nxt_step_cnt;
  reg [MEM_AW-1:0] nxt_ptr;
  reg              nxt_phase;
  reg              nxt_chip;
  reg [NSECT-1:0]  nxt_mask;
  reg [2:0]        nxt_nsec;
  reg [MEM_AW-1:0] nxt_pa;
  reg [15:0]       nxt_pd;
  reg              nxt_susp_req;
  reg              mem_we;
  reg [MEM_AW-1:0] mem_wi;
  reg [15:0]       mem_wd;
  reg              nxt_tog6;
  reg              nxt_tog2;
  reg [15:0]       nxt_rdata;

  wire [MEM_AW-1:0] acc_idx = fl_addr[MEM_AW:1];
  wire [SB-1:0]     acc_sec = acc_idx[MEM_AW-1 -: SB];
  wire [SB-1:0]     ptr_sec = ptr_ff[MEM_AW-1 -: SB];
  wire [SB-1:0]     pa_sec  = pa_ff[MEM_AW-1 -: SB];
  wire is_u1 = (fl_addr == `FCS_UNLOCK1_ADDR) && (fl_wdata == `FCS_UNLOCK1_DATA);
  wire is_u2 = (fl_addr == `FCS_UNLOCK2_ADDR) && (fl_wdata == `FCS_UNLOCK2_DATA);
  wire nxt_rdy = (nxt_op == OP_READ) || (nxt_op == OP_SUSP);
  wire step_end = (step_cnt_ff == STEP_CYC - 1);

  // command interpreter and operation sequencer
  always @* begin
    nxt_op       = op_ff;
    nxt_cmd      = cmd_ff;
    nxt_win_cnt  = win_cnt_ff;
    nxt_step_cnt = step_cnt_ff;
    nxt_ptr      = ptr_ff;
    nxt_phase    = phase_ff;
    nxt_chip     = chip_ff;
    nxt_mask     = mask_ff;
    nxt_nsec     = nsec_ff;
    nxt_pa       = pa_ff;
    nxt_pd       = pd_ff;
    nxt_susp_req = susp_req_ff;
    mem_we       = 1'b0;
    mem_wi       = ptr_ff;
    mem_wd       = 16'h0000;
    case (op_ff)
      OP_READ, OP_SUSP: begin
        if (fl_wr) begin
          case (cmd_ff)
            C_IDLE: begin
              if (is_u1) begin
                nxt_cmd = C_U1;
              end else if (op_ff == OP_SUSP && fl_wdata == `FCS_CMD_RESUME) begin
                nxt_op       = OP_ERASE;
                nxt_step_cnt = 16'h0000;
              end
            end
            C_U1: nxt_cmd = is_u2 ? C_U2 : C_IDLE;
            C_U2: begin
              nxt_cmd = C_IDLE;
              if (fl_addr == `FCS_UNLOCK1_ADDR && fl_wdata == `FCS_CMD_PROG) begin
                nxt_cmd = C_PSET;
              end else if (op_ff == OP_READ && fl_addr == `FCS_UNLOCK1_ADDR &&
                           fl_wdata == `FCS_CMD_ESETUP) begin
                nxt_cmd = C_ESET;
              end
            end
            C_PSET: begin
              nxt_cmd      = C_IDLE;
              nxt_pa       = acc_idx;
              nxt_pd       = fl_wdata;
              nxt_step_cnt = 16'h0000;
              if (op_ff == OP_READ) begin
                nxt_op = OP_PROG;
              end else if (!mask_ff[acc_sec]) begin
                nxt_op = OP_SPROG;
              end
            end
            C_ESET: nxt_cmd = is_u1 ? C_EU1 : C_IDLE;
            C_EU1:  nxt_cmd = is_u2 ? C_EU2 : C_IDLE;
            C_EU2: begin
              nxt_cmd      = C_IDLE;
              nxt_ptr      = {MEM_AW{1'b0}};
              nxt_phase    = 1'b0;
              nxt_step_cnt = 16'h0000;
              if (fl_addr == `FCS_CHIP_ADDR && fl_wdata == `FCS_CMD_CHIP) begin
                nxt_op   = OP_ERASE;
                nxt_chip = 1'b1;
              end else if (fl_wdata == `FCS_CMD_SECTOR) begin
                nxt_op      = OP_WIN;
                nxt_mask    = {NSECT{1'b0}};
                nxt_mask[acc_sec] = 1'b1;
                nxt_nsec    = 3'd1;
                nxt_win_cnt = 13'd0;
              end
            end
            default: nxt_cmd = C_IDLE;
          endcase
        end
      end
      OP_WIN: begin
        nxt_win_cnt = win_cnt_ff + 13'd1;
        if (fl_wr) begin
          if (fl_wdata == `FCS_CMD_SUSPEND) begin
            nxt_op = OP_SUSP;
          end else if (fl_wdata == `FCS_CMD_SECTOR) begin
            nxt_win_cnt = 13'd0;
            // a seventh distinct sector is dropped, the window still restarts
            if (!mask_ff[acc_sec] && nsec_ff < `FCS_MAX_SECTORS) begin
              nxt_mask[acc_sec] = 1'b1;
              nxt_nsec = nsec_ff + 3'd1;
            end
          end else begin
            nxt_op   = OP_READ;
            nxt_mask = {NSECT{1'b0}};
            nxt_nsec = 3'd0;
          end
        end else if (win_cnt_ff == TOUT_CYC - 1) begin
          nxt_op = OP_ERASE;
        end
      end
      OP_ERASE: begin
        nxt_step_cnt = step_end ? 16'h0000 : step_cnt_ff + 16'h0001;
        if (fl_wr && !chip_ff && fl_wdata == `FCS_CMD_SUSPEND) begin
          nxt_susp_req = 1'b1;
          nxt_step_cnt = 16'h0000;
        end
        if (susp_req_ff) begin
          // halt at the word boundary; the latency count caps the wait
          nxt_step_cnt = step_cnt_ff + 16'h0001;
          if (step_end || step_cnt_ff == SUSP_CYC - 1) begin
            nxt_op       = OP_SUSP;
            nxt_susp_req = 1'b0;
            nxt_step_cnt = 16'h0000;
          end
        end else if (step_end) begin
          if (chip_ff || mask_ff[ptr_sec]) begin
            mem_we = 1'b1;
            mem_wd = phase_ff ? 16'hFFFF : 16'h0000;
          end
          nxt_ptr = ptr_ff + {{(MEM_AW-1){1'b0}}, 1'b1};
          if (&ptr_ff) begin
            nxt_phase = 1'b1;
            if (phase_ff) begin
              nxt_op    = OP_READ;
              nxt_mask  = {NSECT{1'b0}};
              nxt_nsec  = 3'd0;
              nxt_chip  = 1'b0;
              nxt_phase = 1'b0;
            end
          end
        end
      end
      OP_PROG, OP_SPROG: begin
        // the write pulse is timed here; commands are not looked at
        nxt_step_cnt = step_cnt_ff + 16'h0001;
        if (step_cnt_ff == PROG_CYC - 1) begin
          mem_we       = 1'b1;
          mem_wi       = pa_ff;
          mem_wd       = mem[pa_ff] & pd_ff;
          nxt_step_cnt = 16'h0000;
          nxt_op       = (op_ff == OP_PROG) ? OP_READ : OP_SUSP;
        end
      end
      default: nxt_op = OP_READ;
    endcase
  end

  // read path: array data or polled status
  always @* begin
    nxt_tog6  = tog6_ff;
    nxt_tog2  = tog2_ff;
    nxt_rdata = mem[acc_idx];
    if (fl_rd) begin
      case (op_ff)
        OP_PROG, OP_SPROG: begin
          if (op_ff == OP_SPROG && mask_ff[acc_sec]) begin
            nxt_rdata = 16'h0000;
            nxt_rdata[`FCS_POLL_BIT] = 1'b1;
            nxt_rdata[`FCS_TOG6_BIT] = 1'b1;
            nxt_rdata[`FCS_TOG2_BIT] = tog2_ff;
            nxt_tog2 = ~tog2_ff;
          end else begin
            nxt_rdata = 16'h0000;
            nxt_rdata[`FCS_POLL_BIT] = ~pd_ff[`FCS_POLL_BIT];
            nxt_rdata[`FCS_TOG6_BIT] = tog6_ff;
            nxt_rdata[`FCS_TOG2_BIT] = 1'b1;
            nxt_tog6 = ~tog6_ff;
          end
        end
        OP_WIN, OP_ERASE: begin
          nxt_rdata = 16'h0000;
          nxt_rdata[`FCS_TOG6_BIT] = tog6_ff;
          nxt_rdata[`FCS_WIN_BIT]  = (op_ff == OP_ERASE);
          nxt_rdata[`FCS_TOG2_BIT] = tog2_ff;
          nxt_tog6 = ~tog6_ff;
          nxt_tog2 = ~tog2_ff;
        end
        OP_SUSP: begin
          if (mask_ff[acc_sec]) begin
            nxt_rdata = 16'h0000;
            nxt_rdata[`FCS_POLL_BIT] = 1'b1;
            nxt_rdata[`FCS_TOG6_BIT] = 1'b1;
            nxt_rdata[`FCS_TOG2_BIT] = tog2_ff;
            nxt_tog2 = ~tog2_ff;
          end
        end
        default: nxt_rdata = mem[acc_idx];
      endcase
    end
  end

  always @(posedge clk) begin
    if (mem_we) begin
      mem[mem_wi] <= mem_wd;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      op_ff        <= OP_READ;
      cmd_ff       <= C_IDLE;
      win_cnt_ff   <= 13'd0;
      step_cnt_ff  <= 16'h0000;
      ptr_ff       <= {MEM_AW{1'b0}};
      phase_ff     <= 1'b0;
      chip_ff      <= 1'b0;
      mask_ff      <= {NSECT{1'b0}};
      nsec_ff      <= 3'd0;
      pa_ff        <= {MEM_AW{1'b0}};
      pd_ff        <= 16'h0000;
      susp_req_ff  <= 1'b0;
      tog6_ff      <= 1'b0;
      tog2_ff      <= 1'b0;
      fl_rdata_ff  <= 16'h0000;
      fl_rvalid_ff <= 1'b0;
      ready_busy_line_ff <= 1'b1;
    end else begin
      op_ff        <= nxt_op;
      cmd_ff       <= nxt_cmd;
      win_cnt_ff   <= nxt_win_cnt;
      step_cnt_ff  <= nxt_step_cnt;
      ptr_ff       <= nxt_ptr;
      phase_ff     <= nxt_phase;
      chip_ff      <= nxt_chip;
      mask_ff      <= nxt_mask;
      nsec_ff      <= nxt_nsec;
      pa_ff        <= nxt_pa;
      pd_ff        <= nxt_pd;
      susp_req_ff  <= nxt_susp_req;
      tog6_ff      <= nxt_tog6;
      tog2_ff      <= nxt_tog2;
      fl_rdata_ff  <= fl_rd ? nxt_rdata : fl_rdata_ff;
      fl_rvalid_ff <= fl_rd;
      ready_busy_line_ff <= nxt_rdy;
    end
  end

  // apb slave: one wait state, single status/control word
  wire apb_setup  = psel && penable && !pready_ff;
  wire apb_access = psel && penable && pready_ff;
  wire stat_hit   = (paddr == `FCS_STAT_OFS);
  wire flag_set   = nxt_rdy && !ready_busy_line_ff;

  always @(posedge clk) begin
    if (rst) begin
      pready_ff      <= 1'b0;
      pslverr_ff     <= 1'b0;
      prdata_ff      <= 32'h00000000;
      flag_ff        <= `FCS_RST_FLAG;
      ien_ff         <= `FCS_RST_IEN;
      op_done_irq_ff <= 1'b0;
    end else begin
      pready_ff <= apb_setup;
      if (apb_setup) begin
        pslverr_ff <= !stat_hit;
        prdata_ff  <= 32'h00000000;
        if (stat_hit && !pwrite) begin
          prdata_ff[`FCS_STAT_RDY_BIT]  <= ready_busy_line_ff;
          prdata_ff[`FCS_STAT_FLAG_BIT] <= flag_ff;
          prdata_ff[`FCS_STAT_IEN_BIT]  <= ien_ff;
          prdata_ff[`FCS_STAT_WIN_BIT]  <= (op_ff == OP_WIN);
          prdata_ff[`FCS_STAT_SUSP_BIT] <= (op_ff == OP_SUSP) || (op_ff == OP_SPROG);
        end
      end
      if (apb_access && pwrite && stat_hit) begin
        ien_ff <= pwdata[`FCS_STAT_IEN_BIT];
      end
      // a completion in the clearing cycle keeps the flag set
      if (flag_set) begin
        flag_ff <= 1'b1;
      end else if (apb_access && pwrite && stat_hit && !pwdata[`FCS_STAT_FLAG_BIT]) begin
        flag_ff <= 1'b0;
      end
      op_done_irq_ff <= (flag_ff || flag_set) && ien_ff;
    end
  end

endmodule
`default_nettype wire

// file: fcs_unused_placeholder_never.v
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// file: fcs_chk.sv
`timescale 1ns/1ns
`default_nettype none
`include "fcs_consts.vh"
module fcs_chk (
  input wire logic        clk,                // clock
  input wire logic        rst,                // reset
  input wire logic        fl_wr,              // write strobe
  input wire logic        fl_rd,              // read strobe
  input wire logic [19:0] fl_addr,            // offset
  input wire logic [15:0] fl_wdata,           // write data
  input wire logic [15:0] fl_rdata_ff,        // read data
  input wire logic        fl_rvalid_ff,       // read valid
  input wire logic        psel,               // apb select
  input wire logic        penable,            // apb enable
  input wire logic [31:0] prdata_ff,          // apb data
  input wire logic        pready_ff,          // apb ready
  input wire logic        pslverr_ff,         // apb error
  input wire logic        ready_busy_line_ff, // ready
  input wire logic        op_done_irq_ff      // irq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // ready at the first unlock keeps sequences written while busy out
  sequence s_prog;
    fl_wr && fl_addr == `FCS_UNLOCK1_ADDR && fl_wdata == `FCS_UNLOCK1_DATA && ready_busy_line_ff
    ##2 fl_wr && fl_addr == `FCS_UNLOCK2_ADDR && fl_wdata == `FCS_UNLOCK2_DATA
    ##2 fl_wr && fl_addr == `FCS_UNLOCK1_ADDR && fl_wdata == `FCS_CMD_PROG ##2 fl_wr;
  endsequence
  a_prog_busy: assert property (s_prog |-> ##[1:3] !ready_busy_line_ff)
    else $error("program sequence did not start busy");
  a_rvalid_lat: assert property (fl_rd |=> fl_rvalid_ff)
    else $error("read not answered next cycle");
  a_rvalid_cause: assert property (fl_rvalid_ff |-> $past(fl_rd))
    else $error("read valid without read");
  a_rdata_hold: assert property (!fl_rd |=> $stable(fl_rdata_ff))
    else $error("read data moved without read");
  a_pready_lat: assert property (psel && penable && !pready_ff |=> pready_ff)
    else $error("apb access not answered");
  a_pready_one: assert property (pready_ff |=> !pready_ff)
    else $error("apb ready wider than one cycle");
  a_err_zero: assert property (pready_ff && pslverr_ff |-> prdata_ff == 32'h0)
    else $error("error response with data");
  a_irq_ready: assert property ($rose(op_done_irq_ff) |-> ready_busy_line_ff)
    else $error("irq rose while busy");
  a_rst_vals: assert property (disable iff (1'b0)
    rst |=> ready_busy_line_ff && !op_done_irq_ff && !pready_ff && !fl_rvalid_ff)
    else $error("reset values wrong");
  c_prog: cover property (s_prog);
  c_err: cover property (pready_ff && pslverr_ff);
  c_done: cover property ($rose(ready_busy_line_ff));
endmodule
bind fcs_flash_command_sequencer fcs_chk i_chk (.clk(clk), .rst(rst), .fl_wr(fl_wr), .fl_rd(fl_rd),
  .fl_addr(fl_addr), .fl_wdata(fl_wdata), .fl_rdata_ff(fl_rdata_ff), .fl_rvalid_ff(fl_rvalid_ff),
  .psel(psel), .penable(penable), .prdata_ff(prdata_ff), .pready_ff(pready_ff),
  .pslverr_ff(pslverr_ff), .ready_busy_line_ff(ready_busy_line_ff), .op_done_irq_ff(op_done_irq_ff));
`default_nettype wire

// file: fcs_core_model.sv
`timescale 1ns/1ns
`default_nettype none
module fcs_core_model (
  input  wire logic        clk,        // clock
  output var  logic        fl_wr,      // write strobe
  output var  logic        fl_rd,      // read strobe
  output var  logic [19:0] fl_addr,    // offset
  output var  logic [15:0] fl_wdata,   // write data
  input  wire logic [15:0] fl_rdata_ff // read data
);
  initial begin
    fl_wr = 1'b0;
    fl_rd = 1'b0;
    fl_addr = 20'h00000;
    fl_wdata = 16'h0000;
  end
  // one half-word per strobe cycle
  task automatic wr(input logic [19:0] a, input logic [15:0] d);
    @(posedge clk);
    fl_wr <= 1'b1;
    fl_addr <= a;
    fl_wdata <= d;
    @(posedge clk);
    fl_wr <= 1'b0;
    // released lines carry junk so stale values cannot pass
    fl_addr <= ~a;
    fl_wdata <= ~d;
  endtask
  task automatic rd(input logic [19:0] a, output logic [15:0] q);
    @(posedge clk);
    fl_rd <= 1'b1;
    fl_addr <= a;
    @(posedge clk);
    fl_rd <= 1'b0;
    fl_addr <= ~a;
    @(posedge clk);
    q = fl_rdata_ff;
  endtask
endmodule
`default_nettype wire

// file: tb_flash_command_sequencer.sv
`timescale 1ns/1ns
`default_nettype none
`include "fcs_consts.vh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fails++; $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
module tb_flash_command_sequencer;
  localparam int TOUT = 20;
  localparam int STEP = 4;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  wire logic        fl_wr, fl_rd, fl_rvalid_ff, pready_ff, pslverr_ff, ready_busy_line_ff, op_done_irq_ff;
  wire logic [19:0] fl_addr;
  wire logic [15:0] fl_wdata, fl_rdata_ff;
  wire logic [31:0] prdata_ff;
  logic [32:0] eq[$], mq[$], e, m;
  logic [15:0] mem[16];
  logic [15:0] lf = 16'h0008;
  logic [15:0] q, q2;
  int          pw[4] = '{13, 5, 0, 13};
  int          checked = 0, fails = 0, cyc = 0, n;
  always #5 clk = ~clk;
  fcs_flash_command_sequencer #(.MEM_AW(4), .SB(3), .STEP_CYC(STEP), .PROG_CYC(8), .TOUT_CYC(TOUT)) i_dut (
    .clk(clk), .rst(rst), .fl_wr(fl_wr), .fl_rd(fl_rd), .fl_addr(fl_addr), .fl_wdata(fl_wdata),
    .fl_rdata_ff(fl_rdata_ff), .fl_rvalid_ff(fl_rvalid_ff), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_ff(prdata_ff), .pready_ff(pready_ff),
    .pslverr_ff(pslverr_ff), .ready_busy_line_ff(ready_busy_line_ff), .op_done_irq_ff(op_done_irq_ff));
  fcs_core_model i_core (.clk(clk), .fl_wr(fl_wr), .fl_rd(fl_rd), .fl_addr(fl_addr),
    .fl_wdata(fl_wdata), .fl_rdata_ff(fl_rdata_ff));
  function automatic logic [15:0] nxt(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  function automatic logic [19:0] ad(input int i);
    return {15'h0000, i[3:0], 1'b0};
  endfunction
  task automatic tally_and_finish();
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic unl();
    i_core.wr(`FCS_UNLOCK1_ADDR, `FCS_UNLOCK1_DATA);
    i_core.wr(`FCS_UNLOCK2_ADDR, `FCS_UNLOCK2_DATA);
  endtask
  task automatic prog(input int i, input logic [15:0] v);
    unl();
    i_core.wr(`FCS_UNLOCK1_ADDR, `FCS_CMD_PROG);
    i_core.wr(ad(i), v);
  endtask
  task automatic esu();
    unl();
    i_core.wr(`FCS_UNLOCK1_ADDR, `FCS_CMD_ESETUP);
    unl();
  endtask
  task automatic rd(input int i, input logic [15:0] ev, input logic [15:0] mk);
    eq.push_back({17'h00000, ev});
    mq.push_back({17'h00000, mk});
    i_core.rd(ad(i), q);
  endtask
  task automatic chk_all();
    for (int i = 0; i < 16; i++) rd(i, mem[i], 16'hFFFF);
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] v,
                     input logic [32:0] ev, input logic [32:0] mk);
    if (wr === 1'b0) begin
      eq.push_back(ev);
      mq.push_back(mk);
    end
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= v;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready_ff !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wrdy(input logic v);
    while (ready_busy_line_ff !== v) @(posedge clk);
  endtask
  // whole run needs under 1000 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      tally_and_finish();
    end
    if (fl_rvalid_ff === 1'b1 || (pready_ff === 1'b1 && pwrite === 1'b0)) begin
      e = eq.pop_front();
      m = mq.pop_front();
      `CHK((fl_rvalid_ff ? {17'h00000, fl_rdata_ff} : {pslverr_ff, prdata_ff}) & m, e)
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    `CHK(ready_busy_line_ff, 1'b1)
    apb(1'b0, 12'h000, 32'h0, 33'h1, {33{1'b1}});
    apb(1'b0, 12'h004, 32'h0, {1'b1, 32'h0}, {33{1'b1}});
    $display("end reset");
    esu();
    i_core.wr(`FCS_CHIP_ADDR, `FCS_CMD_CHIP);
    rd(7, 16'h0000, 16'h0080);
    i_core.wr(ad(3), `FCS_CMD_SUSPEND);
    prog(2, 16'h0000);
    `CHK(ready_busy_line_ff, 1'b0)
    wrdy(1'b1);
    foreach (mem[i]) mem[i] = 16'hFFFF;
    chk_all();
    apb(1'b0, 12'h000, 32'h0, 33'h3, {33{1'b1}});
    apb(1'b1, 12'h000, 32'h6, 33'h0, 33'h0);
    repeat (2) @(posedge clk);
    `CHK(op_done_irq_ff, 1'b1)
    apb(1'b1, 12'h000, 32'h4, 33'h0, 33'h0);
    repeat (2) @(posedge clk);
    `CHK(op_done_irq_ff, 1'b0)
    $display("end chip erase");
    foreach (pw[k]) begin
      lf = nxt(lf);
      prog(pw[k], lf);
      mem[pw[k]] = mem[pw[k]] & lf;
      rd(pw[k], {8'h00, ~lf[7], 7'h04}, 16'h0084);
      i_core.wr(ad(9), `FCS_CMD_SUSPEND);
      `CHK(ready_busy_line_ff, 1'b0)
      wrdy(1'b1);
      `CHK(op_done_irq_ff, 1'b1)
      rd(pw[k], mem[pw[k]], 16'hFFFF);
    end
    $display("end program");
    i_core.wr(`FCS_UNLOCK1_ADDR, `FCS_UNLOCK1_DATA);
    i_core.wr(`FCS_UNLOCK2_ADDR, 16'h1234);
    i_core.wr(`FCS_UNLOCK1_ADDR, `FCS_CMD_PROG);
    i_core.wr(ad(0), 16'h0000);
    rd(0, mem[0], 16'hFFFF);
    unl();
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    i_core.wr(`FCS_UNLOCK1_ADDR, `FCS_CMD_PROG);
    i_core.wr(ad(0), 16'h0000);
    rd(0, mem[0], 16'hFFFF);
    apb(1'b0, 12'h000, 32'h0, 33'h1, {33{1'b1}});
    $display("end abort");
    esu();
    i_core.wr(ad(3), `FCS_CMD_SECTOR);
    rd(3, 16'h0000, 16'h0088);
    apb(1'b0, 12'h000, 32'h0, 33'h8, 33'h8);
    i_core.wr(ad(12), `FCS_CMD_SECTOR);
    repeat (TOUT + 4) @(posedge clk);
    rd(12, 16'h0008, 16'h0088);
    wrdy(1'b1);
    foreach (mem[i]) if (i / 2 == 1 || i / 2 == 6) mem[i] = 16'hFFFF;
    chk_all();
    esu();
    i_core.wr(ad(4), `FCS_CMD_SECTOR);
    i_core.wr(`FCS_UNLOCK1_ADDR, 16'hF0F0);
    repeat (TOUT + 4) @(posedge clk);
    `CHK(ready_busy_line_ff, 1'b1)
    chk_all();
    $display("end sector erase");
    esu();
    i_core.wr(ad(5), `FCS_CMD_SECTOR);
    repeat (TOUT + 8) @(posedge clk);
    lf = nxt(lf);
    i_core.wr({lf, 4'h0}, `FCS_CMD_SUSPEND);
    n = 0;
    while (ready_busy_line_ff !== 1'b1 && n < 50) begin
      n++;
      @(posedge clk);
    end
    `CHK(n <= STEP + 3, 1'b1)
    rd(5, 16'h00C0, 16'h00C0);
    q2 = q;
    rd(4, 16'h00C0, 16'h00C0);
    `CHK(q[2] ^ q2[2], 1'b1)
    rd(12, mem[12], 16'hFFFF);
    apb(1'b0, 12'h000, 32'h0, 33'h11, 33'h11);
    lf = nxt(lf);
    prog(0, lf);
    mem[0] = mem[0] & lf;
    wrdy(1'b0);
    wrdy(1'b1);
    rd(0, mem[0], 16'hFFFF);
    i_core.wr(ad(9), `FCS_CMD_RESUME);
    wrdy(1'b0);
    i_core.wr(ad(1), `FCS_CMD_SUSPEND);
    repeat (STEP + 3) @(posedge clk);
    `CHK(ready_busy_line_ff, 1'b1)
    i_core.wr(ad(9), `FCS_CMD_RESUME);
    wrdy(1'b0);
    wrdy(1'b1);
    mem[4] = 16'hFFFF;
    mem[5] = 16'hFFFF;
    chk_all();
    $display("end suspend");
    tally_and_finish();
  end
endmodule
`default_nettype wire
